/* File: hw/irq_vectoring.sv */
// irq_vectoring: prioritises dma channel and peripheral-bus interrupts onto
// an 8-bit expanded-mode vector bus, with axi4-lite registers.
// assumes inputs synchronous to aclk; dma event pulses come from channel logic.
// Behaviour
// - every dma channel has seven sources: two normal, five error
// - normal sources masked per channel control; error sources never masked
// - dma channel vector is 71 minus the channel number
// - dma vectors rank below every peripheral-bus input
// - reading a channel status register clears its active bits
// - acknowledge cycle time set by the pulse-width register
// - two reserved local inputs and five peripheral inputs, one high priority
// - acknowledge is programmable as single or double pulse
// - acknowledge pulse width is programmable
// - each peripheral input individually maskable, masked inputs ignored except by the device-vector capture
// - drive 8-bit vector bus, translating each active input
// - up to two peripheral devices may supply their own vector
// - input 0 ranks highest, device vector within 207-168
// - input 1 ranks next, device vector within 167-128
// - input 2 gives vector 120, input 3 gives vector 112
// - inputs not latched; a dropped input leaves the vector bus on the next edge
// - vector bus always shows highest-priority active input
// - any stop condition can interrupt; interrupt without stop too
`timescale 1ns/100ps
module irq_vectoring #(
    parameter int channels = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // per channel: 7 source pulses, low 2 normal termination, upper 5 error
    input wire logic [channels*7-1:0] dma_event,
    input wire logic [1:0] local_irq,
    input wire logic [4:0] periph_irq,
    input wire logic [7:0] periph_vector,
    output logic [7:0] irq_vector,
    output logic irq_request,
    output logic iack_n,
    output logic iack_busy
);

    logic [1:0] chan_ctrl_q [channels];
    logic [6:0] chan_stat_q [channels];
    logic [7:0] periph_mask_q;
    logic [2:0] iack_ctrl_q;
    logic [7:0] ack_width_q;
    logic [7:0] dev_vec_q;
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [1:0] bresp_q;
    logic do_write;
    logic rd_take;
    logic [7:0] vec_q;
    logic req_q;
    logic [channels-1:0] chan_pend;
    logic [7:0] vec_d;
    logic req_d;
    irq_vec_pkg::ack_state_type ack_state_q;
    logic [7:0] ack_cnt_q;
    logic ack_second_q;
    logic ack_n_q;
    logic iack_start;
    logic [7:0] unused_local;

    // write channels are captured independently so either may come first
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign do_write = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign rd_take = s_axi_arvalid && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write decode and response; registers are a byte wide, lane 0 only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= irq_vec_pkg::resp_okay;
            periph_mask_q <= irq_vec_pkg::mask_reset;
            iack_ctrl_q <= 3'h0;
            ack_width_q <= irq_vec_pkg::width_reset;
            for (int i = 0; i < channels; i++)
            begin
                chan_ctrl_q[i] <= irq_vec_pkg::ctrl_reset;
            end
        end
        else
        begin
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= irq_vec_pkg::resp_okay;
                if (awaddr_q < irq_vec_pkg::stat_base)
                begin
                    if (wstrb_q[0])
                    begin
                        chan_ctrl_q[awaddr_q[4:2]] <= wdata_q[1:0];
                    end
                end
                else if (awaddr_q[7:2] == irq_vec_pkg::periph_mask_off[7:2])
                begin
                    if (wstrb_q[0])
                    begin
                        periph_mask_q <= wdata_q[7:0];
                    end
                end
                else if (awaddr_q[7:2] == irq_vec_pkg::iack_ctrl_off[7:2])
                begin
                    if (wstrb_q[0])
                    begin
                        iack_ctrl_q <= wdata_q[2:0];
                    end
                end
                else if (awaddr_q[7:2] == irq_vec_pkg::ack_pulse_width_off[7:2])
                begin
                    if (wstrb_q[0])
                    begin
                        ack_width_q <= wdata_q[7:0];
                    end
                end
                else if (awaddr_q < irq_vec_pkg::vector_stat_off)
                begin
                    bresp_q <= irq_vec_pkg::resp_okay;
                end
                else
                begin
                    bresp_q <= irq_vec_pkg::resp_slverr;
                end
            end
        end
    end

    // status bits: set wins over the clear-on-read in the same cycle
    genvar g;
    generate
        for (g = 0; g < channels; g++)
        begin : gen_chan
            logic [6:0] ev;
            logic rd_hit;
            assign ev = dma_event[g*7 +: 7];
            assign rd_hit = rd_take && s_axi_araddr[7:5] == irq_vec_pkg::stat_base[7:5]
                && s_axi_araddr[4:2] == 3'(g);
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    chan_stat_q[g] <= 7'h00;
                end
                else
                begin
                    chan_stat_q[g] <= (rd_hit ? 7'h00 : chan_stat_q[g]) | ev;
                end
            end
            // normal bits gated by control, error bits always pass
            assign chan_pend[g] = |(chan_stat_q[g][1:0] & chan_ctrl_q[g])
                || |chan_stat_q[g][6:2];
        end
    endgenerate

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= irq_vec_pkg::resp_okay;
        end
        else
        begin
            if (rvalid_q && s_axi_rready)
            begin
                rvalid_q <= 1'b0;
            end
            if (rd_take)
            begin
                rvalid_q <= 1'b1;
                rresp_q <= irq_vec_pkg::resp_okay;
                rdata_q <= 32'h0000_0000;
                if (s_axi_araddr < irq_vec_pkg::stat_base)
                begin
                    rdata_q[1:0] <= chan_ctrl_q[s_axi_araddr[4:2]];
                end
                else if (s_axi_araddr < irq_vec_pkg::periph_mask_off)
                begin
                    rdata_q[6:0] <= chan_stat_q[s_axi_araddr[4:2]];
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::periph_mask_off[7:2])
                begin
                    rdata_q[7:0] <= periph_mask_q;
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::iack_ctrl_off[7:2])
                begin
                    rdata_q[2:0] <= iack_ctrl_q;
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::ack_pulse_width_off[7:2])
                begin
                    rdata_q[7:0] <= ack_width_q;
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::vector_stat_off[7:2])
                begin
                    rdata_q[8:0] <= {req_q, vec_q};
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::dma_event_off[7:2])
                begin
                    rdata_q[channels-1:0] <= chan_pend;
                end
                else if (s_axi_araddr[7:2] == irq_vec_pkg::periph_vec_off[7:2])
                begin
                    rdata_q[7:0] <= dev_vec_q;
                end
                else
                begin
                    rresp_q <= irq_vec_pkg::resp_slverr;
                end
            end
        end
    end

    // combinational priority over live peripheral inputs and latched dma status
    always_comb
    begin
        vec_d = irq_vec_pkg::idle_vector;
        req_d = 1'b0;
        for (int c = channels - 1; c >= 0; c--)
        begin
            if (chan_pend[c])
            begin
                vec_d = irq_vec_pkg::dma_vector_top - 8'(c);
                req_d = 1'b1;
            end
        end
        // peripheral levels override dma, lowest priority checked first
        if (periph_irq[4] && !periph_mask_q[4])
        begin
            vec_d = irq_vec_pkg::periph4_vector;
            req_d = 1'b1;
        end
        if (periph_irq[3] && !periph_mask_q[3])
        begin
            vec_d = irq_vec_pkg::periph3_vector;
            req_d = 1'b1;
        end
        if (periph_irq[2] && !periph_mask_q[2])
        begin
            vec_d = irq_vec_pkg::periph2_vector;
            req_d = 1'b1;
        end
        if (periph_irq[1] && !periph_mask_q[1])
        begin
            // one shared capture: never show the other input's vector
            vec_d = iack_ctrl_q[irq_vec_pkg::self_vec_1_bit]
                && dev_vec_q <= irq_vec_pkg::periph1_hi ? dev_vec_q
                : irq_vec_pkg::periph1_default;
            req_d = 1'b1;
        end
        if (periph_irq[0] && !periph_mask_q[0])
        begin
            vec_d = iack_ctrl_q[irq_vec_pkg::self_vec_0_bit]
                && dev_vec_q >= irq_vec_pkg::periph0_lo ? dev_vec_q
                : irq_vec_pkg::periph0_default;
            req_d = 1'b1;
        end
    end

    // registered output; a dropped input leaves the bus on the next edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vec_q <= irq_vec_pkg::idle_vector;
            req_q <= 1'b0;
        end
        else
        begin
            vec_q <= vec_d;
            req_q <= req_d;
        end
    end

    // device vectors accepted only inside each input's own window
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dev_vec_q <= irq_vec_pkg::periph0_default;
        end
        else if (!ack_n_q && periph_irq[0]
            && periph_vector >= irq_vec_pkg::periph0_lo
            && periph_vector <= irq_vec_pkg::periph0_hi)
        begin
            dev_vec_q <= periph_vector;
        end
        else if (!ack_n_q && periph_irq[1] && !periph_irq[0]
            && periph_vector >= irq_vec_pkg::periph1_lo
            && periph_vector <= irq_vec_pkg::periph1_hi)
        begin
            dev_vec_q <= periph_vector;
        end
    end

    // acknowledge pulse starts when a self-vectoring input requests while irq_request is low
    assign iack_start = ((periph_irq[0] && !periph_mask_q[0]
        && iack_ctrl_q[irq_vec_pkg::self_vec_0_bit])
        || (periph_irq[1] && !periph_mask_q[1]
        && iack_ctrl_q[irq_vec_pkg::self_vec_1_bit]));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ack_state_q <= irq_vec_pkg::ack_idle;
            ack_cnt_q <= 8'h00;
            ack_second_q <= 1'b0;
            ack_n_q <= 1'b1;
        end
        else
        begin
            case (ack_state_q)
                irq_vec_pkg::ack_idle:
                begin
                    if (iack_start && !req_q)
                    begin
                        ack_state_q <= irq_vec_pkg::ack_pulse;
                        ack_cnt_q <= ack_width_q;
                        ack_second_q <= iack_ctrl_q[irq_vec_pkg::iack_double_bit];
                        ack_n_q <= 1'b0;
                    end
                end
                irq_vec_pkg::ack_pulse:
                begin
                    if (ack_cnt_q == 8'h00)
                    begin
                        ack_n_q <= 1'b1;
                        ack_state_q <= ack_second_q ? irq_vec_pkg::ack_gap
                            : irq_vec_pkg::ack_idle;
                        ack_cnt_q <= 8'(irq_vec_pkg::gap_cycles);
                    end
                    else
                    begin
                        ack_cnt_q <= ack_cnt_q - 8'h01;
                    end
                end
                irq_vec_pkg::ack_gap:
                begin
                    if (ack_cnt_q == 8'h00)
                    begin
                        ack_state_q <= irq_vec_pkg::ack_pulse;
                        ack_cnt_q <= ack_width_q;
                        ack_second_q <= 1'b0;
                        ack_n_q <= 1'b0;
                    end
                    else
                    begin
                        ack_cnt_q <= ack_cnt_q - 8'h01;
                    end
                end
                default:
                begin
                    ack_state_q <= irq_vec_pkg::ack_idle;
                end
            endcase
        end
    end

    // reserved local-bus inputs are accepted but take no part
    assign unused_local = {6'h00, local_irq};
    assign irq_vector = vec_q;
    assign irq_request = req_q;
    assign iack_n = ack_n_q;
    assign iack_busy = ack_state_q != irq_vec_pkg::ack_idle || (|unused_local & 1'b0);

endmodule : irq_vectoring

/* File: shared/irq_vec_pkg.sv */
// irq_vec_pkg: register map, field positions, vectors and timing constants
// for the dma and peripheral-bus interrupt vectoring block.
// assumes a 32-bit axi4-lite register bus and one 100 MHz clock.
package irq_vec_pkg;

    localparam int num_channels = 8;
    localparam int num_sources = 7;
    localparam int num_periph = 5;
    localparam int num_local = 2;

    // register byte offsets; ctrl_base and stat_base start eight-word channel arrays, the rest one word each
    localparam logic [7:0] ctrl_base = 8'h00;
    localparam logic [7:0] stat_base = 8'h20;
    localparam logic [7:0] periph_mask_off = 8'h40;
    localparam logic [7:0] iack_ctrl_off = 8'h44;
    localparam logic [7:0] ack_pulse_width_off = 8'h48;
    localparam logic [7:0] vector_stat_off = 8'h4C;
    localparam logic [7:0] dma_event_off = 8'h50;
    localparam logic [7:0] periph_vec_off = 8'h54;

    // channel control fields: bits 1..0 enable the two normal sources
    localparam int norm_en_lsb = 0;
    localparam int norm_width = 2;
    localparam logic [1:0] ctrl_reset = 2'h0;

    // iack control fields
    localparam int iack_double_bit = 0;
    localparam int self_vec_0_bit = 1;
    localparam int self_vec_1_bit = 2;

    localparam logic [7:0] dma_vector_top = 8'h47;
    localparam logic [7:0] periph2_vector = 8'h78;
    localparam logic [7:0] periph3_vector = 8'h70;
    localparam logic [7:0] periph0_default = 8'hA8;
    localparam logic [7:0] periph1_default = 8'h80;
    localparam logic [7:0] periph0_lo = 8'hA8;
    localparam logic [7:0] periph0_hi = 8'hCF;
    localparam logic [7:0] periph1_lo = 8'h80;
    localparam logic [7:0] periph1_hi = 8'hA7;
    localparam logic [7:0] periph4_vector = 8'h7C;
    localparam logic [7:0] idle_vector = 8'h00;

    localparam logic [7:0] mask_reset = 8'hFF;
    localparam logic [7:0] width_reset = 8'h0C;
    localparam int gap_ns = 20;
    localparam int clk_period_ns = 10;
    localparam int gap_cycles = (gap_ns + clk_period_ns - 1) / clk_period_ns;

    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef enum logic [1:0] {
        ack_idle,
        ack_pulse,
        ack_gap
    } ack_state_type;

endpackage : irq_vec_pkg

/* File: tb/dma_and_bus_interrupt_vectoring_tb.sv */
// dma_and_bus_interrupt_vectoring_tb: self-checking bench for irq_vectoring.
// assumes the axi4-lite map and timing of irq_vectoring.
`timescale 1ns/100ps
bind irq_vectoring irq_vec_props u_props (.aclk(aclk), .aresetn(aresetn),
    .periph_irq(periph_irq), .irq_vector(irq_vector), .irq_request(irq_request),
    .iack_n(iack_n), .iack_busy(iack_busy));
module dma_and_bus_interrupt_vectoring_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic [31:0] s_axi_rdata, rd_d;
    logic [55:0] dma_event = 56'h0;
    logic [1:0] local_irq = 2'h0;
    logic [4:0] periph_irq = 5'h00;
    logic [7:0] periph_vector, irq_vector;
    logic [7:0] dev_vec = 8'hB4;
    logic irq_request, iack_n, iack_busy;
    logic iack_prev = 1'h1;
    int n_fail = 0;
    int cmp_count = 0;
    int low_cnt = 0;
    int falls = 0;

    irq_vectoring #(.channels(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dma_event(dma_event),
        .local_irq(local_irq), .periph_irq(periph_irq), .periph_vector(periph_vector),
        .irq_vector(irq_vector), .irq_request(irq_request), .iack_n(iack_n),
        .iack_busy(iack_busy));
    periph_dev u_dev (.aclk(aclk), .iack_n(iack_n), .dev_vec(dev_vec),
        .periph_vector(periph_vector));

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    // counted on the edge, where the registered acknowledge is still the settled value
    always @(posedge aclk)
    begin
        if (!iack_n) low_cnt++;
        if (iack_prev && !iack_n) falls++;
        iack_prev = iack_n;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic w(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : w

    // handshakes judged mid-cycle, where combinational ready has settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b_t = 1'h0;
        while (!b_t)
        begin
            @(negedge aclk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bvalid & s_axi_bready;
            if (b_t) chk("write resp", 32'(s_axi_bresp), 32'(irq_vec_pkg::resp_okay));
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
            if (b_t) s_axi_bready <= 1'h0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        r_t = 1'h0;
        while (!r_t)
        begin
            @(negedge aclk);
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rvalid & s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'h0;
            if (r_t) s_axi_rready <= 1'h0;
        end
    endtask : rd

    task automatic ev(input int b);
        @(posedge aclk);
        dma_event <= 56'h1 << b;
        @(posedge aclk);
        dma_event <= 56'h0;
    endtask : ev

    task automatic drv(input logic [4:0] p);
        @(posedge aclk);
        periph_irq <= p;
    endtask : drv

    task automatic t_reset;
        w(0);
        chk("vector idle", 32'(irq_vector), 32'h0);
        chk("request idle", 32'(irq_request), 32'h0);
        rd(irq_vec_pkg::ack_pulse_width_off, rd_d, rd_r);
        chk("width reset", rd_d, 32'(irq_vec_pkg::width_reset));
        rd(8'h80, rd_d, rd_r);
        chk("unmapped resp", 32'(rd_r), 32'(irq_vec_pkg::resp_slverr));
        $display("test reset done");
    endtask : t_reset

    task automatic t_dma;
        for (int c = 0; c < 8; c++)
        begin
            ev(c * 7 + 2 + c % 5);
            w(2);
            chk("dma vector", 32'(irq_vector), 32'(71 - c));
            rd(8'(32'h20 + 4 * c), rd_d, rd_r);
            chk("dma status", rd_d, 32'h1 << (2 + c % 5));
            w(3);
            chk("status cleared", 32'(irq_vector), 32'h0);
        end
        ev(21);
        w(3);
        chk("normal masked", 32'(irq_vector), 32'h0);
        rd(8'h2C, rd_d, rd_r);
        wr(8'h0C, 32'h3);
        for (int s = 0; s < 2; s++)
        begin
            ev(21 + s);
            w(2);
            chk("normal vector", 32'(irq_vector), 32'h44);
            rd(8'h2C, rd_d, rd_r);
            chk("normal status", rd_d, 32'h1 << s);
            w(3);
        end
        $display("test dma done");
    endtask : t_dma

    task automatic t_periph;
        logic [4:0] pv [7] = '{5'h08, 5'h18, 5'h0C, 5'h04, 5'h06, 5'h07, 5'h00};
        logic [7:0] ex [7] = '{8'h70, 8'h70, 8'h78, 8'h78, irq_vec_pkg::periph1_default,
            irq_vec_pkg::periph0_default, 8'h42};
        wr(irq_vec_pkg::periph_mask_off, 32'h0);
        ev(5 * 7 + 6);
        for (int i = 0; i < 7; i++)
        begin
            drv(pv[i]);
            w(2);
            chk("periph vector", 32'(irq_vector), 32'(ex[i]));
        end
        drv(5'h0C);
        wr(irq_vec_pkg::periph_mask_off, 32'h4);
        w(2);
        chk("masked input", 32'(irq_vector), 32'h70);
        drv(5'h00);
        w(2);
        chk("dropped input", 32'(irq_vector), 32'h42);
        rd(8'h34, rd_d, rd_r);
        chk("ch5 status", rd_d, 32'h40);
        wr(irq_vec_pkg::periph_mask_off, 32'h0);
        $display("test periph done");
    endtask : t_periph

    task automatic t_iack;
        int n;
        wr(irq_vec_pkg::ack_pulse_width_off, 32'h2);
        for (int d = 0; d < 2; d++)
        begin
            wr(irq_vec_pkg::iack_ctrl_off, 32'(2 + d));
            w(3);
            low_cnt = 0;
            falls = 0;
            drv(5'h01);
            w(3);
            n = 0;
            while (iack_busy && n < 100)
            begin
                w(1);
                n++;
            end
            chk("ack low cycles", 32'(low_cnt), 32'(3 * (d + 1)));
            chk("ack pulses", 32'(falls), 32'(d + 1));
            rd(irq_vec_pkg::periph_vec_off, rd_d, rd_r);
            chk("device vector", rd_d, 32'(dev_vec));
            chk("vector range", 32'(irq_vector >= 8'hA8 && irq_vector <= 8'hCF), 32'h1);
            drv(5'h00);
            w(3);
        end
        $display("test iack done");
    endtask : t_iack

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_dma();
        t_periph();
        t_iack();
        results();
    end

    // whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        #200us;
        n_fail++;
        $display("watchdog expired");
        results();
    end
endmodule : dma_and_bus_interrupt_vectoring_tb

/* File: tb/irq_vec_props.sv */
// irq_vec_props: port-level assertions for the interrupt vectoring block.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module irq_vec_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] periph_irq,
    input wire logic [7:0] irq_vector,
    input wire logic irq_request,
    input wire logic iack_n,
    input wire logic iack_busy
);
    default clocking cb @(posedge aclk);
    endclocking

    a_reset_idle: assert property (
        !aresetn |=> irq_vector == 8'h00 && !irq_request && iack_n)
        else $error("outputs not idle after reset");
    a_idle_vector: assert property (
        disable iff (!aresetn) !irq_request |-> irq_vector == 8'h00)
        else $error("vector not zero while no request");
    a_vector_legal: assert property (
        disable iff (!aresetn)
        irq_request |-> irq_vector inside {8'h70, 8'h78, 8'h7C, [8'h40:8'h47], [8'h80:8'hCF]})
        else $error("vector outside the assigned set");
    a_no_latch: assert property (
        disable iff (!aresetn)
        $past(periph_irq) == 5'h00 |-> !(irq_vector inside {8'h70, 8'h78, 8'h7C, [8'h80:8'hCF]}))
        else $error("peripheral vector held after inputs dropped");
    a_vec120_src: assert property (
        disable iff (!aresetn) irq_vector == 8'h78 |-> $past(periph_irq[2]))
        else $error("vector 120 without input 2");
    a_vec112_src: assert property (
        disable iff (!aresetn) irq_vector == 8'h70 |-> $past(periph_irq[3]))
        else $error("vector 112 without input 3");
    a_rank0_src: assert property (
        disable iff (!aresetn) irq_vector inside {[8'hA8:8'hCF]} |-> $past(periph_irq[0]))
        else $error("input 0 range without input 0");
    a_rank1_src: assert property (
        disable iff (!aresetn) irq_vector inside {[8'h80:8'hA7]} |-> $past(periph_irq[1]))
        else $error("input 1 range without input 1");
    a_ack_busy: assert property (
        disable iff (!aresetn) !iack_n |-> iack_busy)
        else $error("acknowledge low while not busy");
    a_ack_cause: assert property (
        disable iff (!aresetn)
        $fell(iack_n) && !$past(iack_busy) |->
            ($past(periph_irq[0]) || $past(periph_irq[1])) && !$past(irq_request))
        else $error("acknowledge started without a self-vectoring request");
endmodule : irq_vec_props

/* File: tb/periph_dev.sv */
// periph_dev: peripheral that supplies its own vector during acknowledge.
// assumes the bench holds the request line until it has been serviced.
`timescale 1ns/100ps
module periph_dev (
    input wire logic aclk,
    input wire logic iack_n,
    input wire logic [7:0] dev_vec,
    output logic [7:0] periph_vector
);
    logic [7:0] junk_q = 8'h5A;

    // bus not driven outside acknowledge: a changing pattern, never the last value
    always_ff @(posedge aclk)
        junk_q <= ~junk_q;
    assign periph_vector = iack_n ? junk_q : dev_vec;
endmodule : periph_dev
